// [src/rxoh_regs.sv]
// receive overhead capture register bank, eight ports, apb slave
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module rxoh_regs #(
  parameter int SEARCH_CYCLES = rxoh_pkg::SEARCH_CYC,
  parameter int NP = rxoh_pkg::PORTS
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [14:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [NP-1:0] rx_link_bits_vld_i,
  input wire logic [NP-1:0] rx_link_bits_i,
  input wire logic [NP-1:0] link_mf_end_i,
  input wire logic [NP-1:0] rx_code_vld_i,
  input wire logic [NP-1:0][5:0] rx_code_bits_i,
  input wire logic [NP-1:0] slc_vld_i,
  input wire logic [NP-1:0][19:0] slc_fields_i,
  input wire logic [NP-1:0] e1_frame_vld_i,
  input wire logic [NP-1:0][3:0] e1_frame_num_i,
  input wire logic [NP-1:0][7:0] e1_ts0_i,
  input wire logic [NP-1:0] crc_multiframe_hunting_i,
  input wire logic [NP-1:0] signaling_multiframe_hunting_i,
  input wire logic [NP-1:0] frame_align_hunting_i,
  input wire logic [NP-1:0] crc_sync_ok_i,
  output logic [NP-1:0] rx_line_mode_select_o,
  output logic [NP-1:0] rx_framing_select_o,
  output logic [NP-1:0] rx_crc_multiframe_enable_o
);
  rxoh_pkg::rxoh_top_t q, d;
  logic [NP-1:0][5:0] csc_w;

  // ==========================================================
  // per-port crc4 search counters
  rxoh_sync_if sy [NP] ();
  for (genvar gp = 0; gp < NP; gp++) begin : g_cnt
    assign sy[gp].enable = q.ctrl[gp][rxoh_pkg::CTL_MODE] && q.ctrl[gp][rxoh_pkg::CTL_CRC];
    assign sy[gp].hunting = crc_multiframe_hunting_i[gp];
    assign sy[gp].sync_ok = crc_sync_ok_i[gp];
    assign sy[gp].clear = q.ctrl[gp][rxoh_pkg::CTL_SRST];
    assign csc_w[gp] = sy[gp].count;
    rxoh_crc_sync_cnt #(
      .SEARCH_CYCLES(SEARCH_CYCLES)
    ) u_cnt (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .sy(sy[gp].cnt)
    );
    assign rx_line_mode_select_o[gp] = q.ctrl[gp][rxoh_pkg::CTL_MODE];
    assign rx_framing_select_o[gp] = q.ctrl[gp][rxoh_pkg::CTL_FRAMING];
    assign rx_crc_multiframe_enable_o[gp] = q.ctrl[gp][rxoh_pkg::CTL_CRC];
  end

  // ==========================================================
  // address decode, word index = byte address / 4
  logic [2:0] a_port;
  logic [8:0] a_off;
  logic a_in;
  assign a_port = paddr_i[13:11];
  assign a_off = paddr_i[10:2];
  assign a_in = !paddr_i[14] && paddr_i[1:0] == 2'h0;

  // ==========================================================
  // next state: capture, read mux, control writes
  always_comb begin
    logic [7:0] sh;
    logic [7:0] rv;
    logic hit;
    logic e1;
    logic [2:0] fi;
    rxoh_pkg::rxoh_cap_t c;
    sh = '0;
    rv = '0;
    hit = 1'b0;
    e1 = 1'b0;
    fi = '0;
    c = '0;
    d = q;
    for (int p = 0; p < NP; p++) begin
      c = q.cap[p];
      if (q.ctrl[p][rxoh_pkg::CTL_SRST]) begin
        c = '0;
      end else begin
        // link bits shift in from the top so the first one ends in bit 0
        sh = rx_link_bits_vld_i[p] ? {rx_link_bits_i[p], c.lsh[7:1]} : c.lsh;
        c.lsh = sh;
        if (q.ctrl[p][rxoh_pkg::CTL_FRAMING]) begin
          if (rx_link_bits_vld_i[p]) begin
            c.lcnt = c.lcnt + 3'h1;
          end
          if (link_mf_end_i[p]) begin
            c.link = {2'h0, sh[7:2]};
            c.lcnt = '0;
          end
        end else if (rx_link_bits_vld_i[p]) begin
          c.lcnt = c.lcnt + 3'h1;
          if (q.cap[p].lcnt == 3'h7) begin
            c.link = sh;
          end
        end
        if (rx_code_vld_i[p]) begin
          c.code = rx_code_bits_i[p];
        end
        if (slc_vld_i[p]) begin
          c.slc1 = slc_fields_i[p][7:0];
          c.slc2 = {slc_fields_i[p][12:11], rxoh_pkg::SLC_FIX, slc_fields_i[p][10:8]};
          c.slc3 = {1'b1, slc_fields_i[p][19:13]};
        end
        if (e1_frame_vld_i[p]) begin
          fi = e1_frame_num_i[p][3:1];
          if (!e1_frame_num_i[p][0]) begin
            c.af = e1_ts0_i[p];
            c.sia[fi] = e1_ts0_i[p][7];
          end else begin
            c.naf = e1_ts0_i[p];
            c.sina[fi] = e1_ts0_i[p][7];
            c.ra[fi] = e1_ts0_i[p][5];
            c.sa4[fi] = e1_ts0_i[p][4];
            c.sa5[fi] = e1_ts0_i[p][3];
          end
        end
      end
      d.cap[p] = c;
    end

    // shared offsets pick their content from the port's line mode
    c = q.cap[a_port];
    e1 = q.ctrl[a_port][rxoh_pkg::CTL_MODE];
    hit = a_in;
    case (a_off)
      rxoh_pkg::OFF_LINK: begin
        // counter bit 1 is dropped so five bits still span the search window
        rv = e1 ? {csc_w[a_port][5:2], csc_w[a_port][0],
                   crc_multiframe_hunting_i[a_port],
                   signaling_multiframe_hunting_i[a_port],
                   frame_align_hunting_i[a_port]} : c.link;
      end
      rxoh_pkg::OFF_CODE: begin
        rv = e1 ? 8'h00 : {2'h0, c.code};
      end
      rxoh_pkg::OFF_W64: begin
        rv = e1 ? c.af : c.slc1;
      end
      rxoh_pkg::OFF_W65: begin
        rv = e1 ? c.naf : c.slc2;
      end
      rxoh_pkg::OFF_W66: begin
        rv = e1 ? c.sia : c.slc3;
      end
      rxoh_pkg::OFF_SINA: begin
        rv = e1 ? c.sina : 8'h00;
      end
      rxoh_pkg::OFF_RA: begin
        rv = e1 ? c.ra : 8'h00;
      end
      rxoh_pkg::OFF_SA4: begin
        rv = e1 ? c.sa4 : 8'h00;
      end
      rxoh_pkg::OFF_SA5: begin
        rv = e1 ? c.sa5 : 8'h00;
      end
      rxoh_pkg::OFF_CTRL: begin
        rv = {4'h0, q.ctrl[a_port]};
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (!hit) begin
      rv = 8'h00;
    end

    // read data and error are prepared in the setup cycle so both come from flops
    if (psel_i && !penable_i) begin
      d.rdata = rv;
      d.err = !hit;
    end
    // capture registers ignore writes, only the control word takes one
    if (psel_i && penable_i && pwrite_i && hit && a_off == rxoh_pkg::OFF_CTRL) begin
      d.ctrl[a_port] = pwdata_i[3:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // apb answer: no wait states
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && q.err;
  assign prdata_o = {24'h0, q.rdata};

  // ==========================================================
  // checks
  logic t1_d4_0;
  assign t1_d4_0 = q.ctrl[0][rxoh_pkg::CTL_FRAMING] && !q.ctrl[0][rxoh_pkg::CTL_SRST];

  a_link_d4_low: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    t1_d4_0 && link_mf_end_i[0] |=> q.cap[0].link[7:6] == 2'h0)
    else $error("d4 link register upper bits not zero");
  a_link_d4_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    t1_d4_0 && !link_mf_end_i[0] |=> $stable(q.cap[0].link))
    else $error("d4 link register changed off a multiframe boundary");
  a_slc_fixed: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    slc_vld_i[0] && !q.ctrl[0][rxoh_pkg::CTL_SRST]
    |=> q.cap[0].slc2[5:3] == 3'h2 && q.cap[0].slc3[7])
    else $error("slc fixed pattern wrong");
  a_align_take: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    e1_frame_vld_i[0] && !e1_frame_num_i[0][0] && !q.ctrl[0][rxoh_pkg::CTL_SRST]
    |=> q.cap[0].af == $past(e1_ts0_i[0]))
    else $error("align frame byte not captured");
  a_ra_take: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    e1_frame_vld_i[0] && e1_frame_num_i[0] == 4'hf && !q.ctrl[0][rxoh_pkg::CTL_SRST]
    |=> q.cap[0].ra[7] == $past(e1_ts0_i[0][5]))
    else $error("frame 15 remote alarm not in bit 7");
  a_status_live: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    psel_i && !penable_i && a_in && a_off == rxoh_pkg::OFF_LINK
    && q.ctrl[a_port][rxoh_pkg::CTL_MODE]
    |=> prdata_o[2:0] == {$past(crc_multiframe_hunting_i[a_port]),
                          $past(signaling_multiframe_hunting_i[a_port]),
                          $past(frame_align_hunting_i[a_port])})
    else $error("status bits not live");
  a_ro_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    psel_i && penable_i && pwrite_i && a_off != rxoh_pkg::OFF_CTRL |=> $stable(q.ctrl))
    else $error("write to read-only register had an effect");
  a_code_top: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    psel_i && !penable_i && a_in && a_off == rxoh_pkg::OFF_CODE
    |=> prdata_o[7:6] == 2'h0 && !pslverr_o)
    else $error("code register upper bits not zero");
endmodule
`default_nettype wire

// [inc/rxoh_pkg.sv]
// constants and types of the receive overhead capture register bank
//
// Overview of operation
// - T1 link register shows received data link or Fs bits.
// - first received link bit lands in bit 0, last in bit 7.
// - D4 link register updates at multiframe end, Fs bits in bits 5..0.
// - code register keeps last valid six-bit code, bits 7..6 read zero.
// - E1 sync status bits are live, never latched.
// - search counter steps once per expired 8 ms CRC4 search.
// - search counter clears on CRC4 sync or when CRC4 is disabled.
// - search counter saturates at its maximum.
// - six-bit counter, bits 5..2 and 0 shown in bits 7..3.
// - status bit 2 high while hunting CRC4 multiframe alignment.
// - status bit 1 high while hunting CAS multiframe alignment.
// - status bit 0 high while hunting basic frame alignment.
// - three T1 registers hold the SLC-96 link with fixed pattern bits.
// - E1 align register holds Si in bit 7 and FAS in 6..0.
// - E1 non-align register holds Si, one, A, Sa4..Sa8.
// - Si bits of even frames gathered, frame 14 in bit 7.
// - Si bits of odd frames gathered, frame 15 in bit 7.
// - remote alarm bits of odd frames gathered, frame 15 in bit 7.
// - Sa4 bits of odd frames gathered, frame 15 in bit 7.
// - Sa5 bits of odd frames gathered, frame 15 in bit 7.
// - eight ports, each copy at base plus 200h times port index.
// - T1 and E1 share offsets; read content follows line mode.
package rxoh_pkg;
  // ==========================================================
  // map: offsets are word indexes, byte address is four times
  localparam int PORTS = 8;
  localparam logic [8:0] OFF_LINK = 9'h062;
  localparam logic [8:0] OFF_CODE = 9'h063;
  localparam logic [8:0] OFF_W64 = 9'h064;
  localparam logic [8:0] OFF_W65 = 9'h065;
  localparam logic [8:0] OFF_W66 = 9'h066;
  localparam logic [8:0] OFF_SINA = 9'h067;
  localparam logic [8:0] OFF_RA = 9'h068;
  localparam logic [8:0] OFF_SA4 = 9'h069;
  localparam logic [8:0] OFF_SA5 = 9'h06a;
  localparam logic [8:0] OFF_CTRL = 9'h070;
  // ==========================================================
  // control register fields
  localparam int CTL_MODE = 0;
  localparam int CTL_FRAMING = 1;
  localparam int CTL_CRC = 2;
  localparam int CTL_SRST = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [2:0] SLC_FIX = 3'h2;
  // ==========================================================
  // crc4 multiframe search timing
  localparam int SEARCH_MS = 8;
  localparam int CLK_HZ = 50000000;
  localparam int SEARCH_CYC = SEARCH_MS * (CLK_HZ / 1000);
  localparam int TMR_W = 19;
  localparam logic [5:0] CSC_MAX = 6'h3f;
  // ==========================================================
  typedef struct packed {
    logic [TMR_W-1:0] tmr;
    logic [5:0] crc_multiframe_search_count;
  } rxoh_cnt_t;
  typedef struct packed {
    logic [7:0] lsh;
    logic [2:0] lcnt;
    logic [7:0] link;
    logic [5:0] code;
    logic [7:0] slc1;
    logic [7:0] slc2;
    logic [7:0] slc3;
    logic [7:0] af;
    logic [7:0] naf;
    logic [7:0] sia;
    logic [7:0] sina;
    logic [7:0] ra;
    logic [7:0] sa4;
    logic [7:0] sa5;
  } rxoh_cap_t;
  typedef struct packed {
    rxoh_cap_t [PORTS-1:0] cap;
    logic [PORTS-1:0][3:0] ctrl;
    logic [7:0] rdata;
    logic err;
  } rxoh_top_t;
endpackage

// [inc/rxoh_sync_if.sv]
// crc4 search counter hookup between the bank and its counters
`timescale 1ns/1ps
`default_nettype none
interface rxoh_sync_if;
  logic enable;
  logic hunting;
  logic sync_ok;
  logic clear;
  logic [5:0] count;
  modport cnt (input enable, input hunting, input sync_ok, input clear, output count);
  modport user (output enable, output hunting, output sync_ok, output clear, input count);
endinterface
`default_nettype wire

// [src/rxoh_crc_sync_cnt.sv]
// crc4 multiframe search timer and saturating search counter
`timescale 1ns/1ps
`default_nettype none
module rxoh_crc_sync_cnt #(
  parameter int SEARCH_CYCLES = rxoh_pkg::SEARCH_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  rxoh_sync_if.cnt sy
);
  localparam logic [rxoh_pkg::TMR_W-1:0] LAST = rxoh_pkg::TMR_W'(SEARCH_CYCLES - 1);
  rxoh_pkg::rxoh_cnt_t q, d;
  logic tick;

  always_comb begin
    d = q;
    tick = 1'b0;
    if (sy.clear || !sy.enable || sy.sync_ok) begin
      d = '0;
    end else if (sy.hunting) begin
      if (q.tmr == LAST) begin
        d.tmr = '0;
        tick = 1'b1;
        if (q.crc_multiframe_search_count != rxoh_pkg::CSC_MAX) begin
          d.crc_multiframe_search_count = q.crc_multiframe_search_count + 6'h01;
        end
      end else begin
        d.tmr = q.tmr + 1'b1;
      end
    end else begin
      d.tmr = '0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sy.count = q.crc_multiframe_search_count;

  a_csc_step: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    tick && q.crc_multiframe_search_count != rxoh_pkg::CSC_MAX |=> q.crc_multiframe_search_count == $past(q.crc_multiframe_search_count) + 6'h01)
    else $error("search counter did not step on timeout");
  a_csc_hold_max: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    q.crc_multiframe_search_count == rxoh_pkg::CSC_MAX && !sy.clear && sy.enable && !sy.sync_ok |=> q.crc_multiframe_search_count == 6'h3f)
    else $error("search counter left its maximum");
  a_csc_clears: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !sy.enable || sy.sync_ok |=> q.crc_multiframe_search_count == 6'h00)
    else $error("search counter not cleared");
endmodule
`default_nettype wire

// [bench/rxoh_line_model.sv]
// far-side framer model driving the per-port overhead capture strobes
`timescale 1ns/1ps
`default_nettype none
module rxoh_line_model #(
  parameter int NP = 8
) (
  input wire logic core_clk_i,
  output logic [NP-1:0] lk_vld_o,
  output logic [NP-1:0] lk_bit_o,
  output logic [NP-1:0] mf_end_o,
  output logic [NP-1:0] code_vld_o,
  output logic [NP-1:0][5:0] code_o,
  output logic [NP-1:0] slc_vld_o,
  output logic [NP-1:0][19:0] slc_o,
  output logic [NP-1:0] frm_vld_o,
  output logic [NP-1:0][3:0] frm_num_o,
  output logic [NP-1:0][7:0] ts0_o
);
  // ==========================================================
  // strobes, one cycle each
  initial begin
    {lk_vld_o, lk_bit_o, mf_end_o, code_vld_o, code_o} = '0;
    {slc_vld_o, slc_o, frm_vld_o, frm_num_o, ts0_o} = '0;
  end
  // data is inverted as a strobe ends, so a stale value never passes for a fresh capture
  task link_bit(input int p, input logic b);
    @(posedge core_clk_i);
    lk_vld_o[p] <= 1'h1;
    lk_bit_o[p] <= b;
    @(posedge core_clk_i);
    lk_vld_o[p] <= 1'h0;
    lk_bit_o[p] <= ~b;
  endtask
  task mf_end(input int p);
    @(posedge core_clk_i);
    mf_end_o[p] <= 1'h1;
    @(posedge core_clk_i);
    mf_end_o[p] <= 1'h0;
  endtask
  task code(input int p, input logic [5:0] c);
    @(posedge core_clk_i);
    code_vld_o[p] <= 1'h1;
    code_o[p] <= c;
    @(posedge core_clk_i);
    code_vld_o[p] <= 1'h0;
    code_o[p] <= ~c;
  endtask
  task slc(input int p, input logic [19:0] f);
    @(posedge core_clk_i);
    slc_vld_o[p] <= 1'h1;
    slc_o[p] <= f;
    @(posedge core_clk_i);
    slc_vld_o[p] <= 1'h0;
    slc_o[p] <= ~f;
  endtask
  task frame(input int p, input logic [3:0] n, input logic [7:0] t);
    @(posedge core_clk_i);
    frm_vld_o[p] <= 1'h1;
    frm_num_o[p] <= n;
    ts0_o[p] <= t;
    @(posedge core_clk_i);
    frm_vld_o[p] <= 1'h0;
    frm_num_o[p] <= ~n;
    ts0_o[p] <= ~t;
  endtask
endmodule
`default_nettype wire

// [bench/rxoh_regs_tb.sv]
// self-checking bench for the receive overhead capture register bank
`timescale 1ns/1ps
`default_nettype none
module rxoh_regs_tb;
  localparam int NP = 8;
  localparam int SC = 20;
  logic core_clk_i;
  logic rst_n_i;
  logic psel, penable, pwrite, pready, pslverr, rerr;
  logic [14:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [NP-1:0] lvld, lbit, mfe, cvld, svld, fvld, hcrc, hcas, hfas, sok;
  logic [NP-1:0] lmode, lfrm, lcrc;
  logic [NP-1:0][5:0] cbits;
  logic [NP-1:0][19:0] sfld;
  logic [NP-1:0][3:0] fnum;
  logic [NP-1:0][7:0] ts0;
  logic [19:0] f;
  logic [7:0] t, af, naf, sia, sina, ra, sa4, sa5;
  int err_total, checked;
  // ==========================================================
  // clock and instances
  initial begin
    core_clk_i = 1'h0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  rxoh_regs #(.SEARCH_CYCLES(SC), .NP(NP)) i_dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .rx_link_bits_vld_i(lvld), .rx_link_bits_i(lbit),
    .link_mf_end_i(mfe), .rx_code_vld_i(cvld), .rx_code_bits_i(cbits), .slc_vld_i(svld),
    .slc_fields_i(sfld), .e1_frame_vld_i(fvld), .e1_frame_num_i(fnum), .e1_ts0_i(ts0),
    .crc_multiframe_hunting_i(hcrc), .signaling_multiframe_hunting_i(hcas),
    .frame_align_hunting_i(hfas), .crc_sync_ok_i(sok), .rx_line_mode_select_o(lmode),
    .rx_framing_select_o(lfrm), .rx_crc_multiframe_enable_o(lcrc));
  rxoh_line_model #(.NP(NP)) i_line (
    .core_clk_i(core_clk_i), .lk_vld_o(lvld), .lk_bit_o(lbit), .mf_end_o(mfe),
    .code_vld_o(cvld), .code_o(cbits), .slc_vld_o(svld), .slc_o(sfld), .frm_vld_o(fvld),
    .frm_num_o(fnum), .ts0_o(ts0));
  // ==========================================================
  // apb master and compares
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input int port, input logic [8:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= 15'((port - 1) * 'h800 + idx * 4);
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'h1;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) begin
      chk("pready", 32'h1, 32'h0);
      test_done();
    end
  endtask
  task automatic rd(input int port, input logic [8:0] idx, input logic [7:0] exp, input string s);
    apb(1'h0, port, idx, 32'h0);
    chk(s, {24'h0, exp}, rdat);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // tests
  initial begin
    err_total = 0;
    checked = 0;
    rst_n_i = 1'h0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {hcrc, hcas, hfas, sok} = '0;
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'h1;
    for (int i = 'h62; i <= 'h6a; i++) rd(1, 9'(i), 8'h00, "reset value");
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      i_line.link_bit(2, i[0] ^ i[2] ^ i[1]);
      if (i == 6) rd(3, rxoh_pkg::OFF_LINK, 8'h00, "partial link");
    end
    rd(3, rxoh_pkg::OFF_LINK, 8'h96, "esf link");
    rd(4, rxoh_pkg::OFF_LINK, 8'h00, "other port");
    apb(1'h1, 3, rxoh_pkg::OFF_CTRL, 32'h8);
    rd(3, rxoh_pkg::OFF_LINK, 8'h00, "soft reset");
    apb(1'h1, 3, rxoh_pkg::OFF_CTRL, 32'h0);
    $display("test esf link done");
    // port 1 carries the d4, slc and e1 frame traffic so the port-0 checks see it
    apb(1'h1, 1, rxoh_pkg::OFF_CTRL, 32'h2);
    for (int i = 0; i < 6; i++) i_line.link_bit(0, i[0] | i[2]);
    rd(1, rxoh_pkg::OFF_LINK, 8'h00, "d4 before boundary");
    i_line.mf_end(0);
    rd(1, rxoh_pkg::OFF_LINK, 8'h3a, "d4 link");
    chk("framing select", 32'h1, {24'h0, lfrm});
    $display("test d4 link done");
    i_line.code(4, 6'h2b);
    rd(5, rxoh_pkg::OFF_CODE, 8'h2b, "code");
    apb(1'h1, 5, rxoh_pkg::OFF_CODE, 32'hff);
    rd(5, rxoh_pkg::OFF_CODE, 8'h2b, "code after write");
    f = 20'h5a6c3;
    i_line.slc(0, f);
    rd(1, rxoh_pkg::OFF_W64, f[7:0], "slc one");
    rd(1, rxoh_pkg::OFF_W65, {f[12], f[11], 3'h2, f[10:8]}, "slc two");
    rd(1, rxoh_pkg::OFF_W66, {1'h1, f[19:16], f[15], f[14], f[13]}, "slc three");
    $display("test code and slc done");
    apb(1'h1, 1, rxoh_pkg::OFF_CTRL, 32'h1);
    apb(1'h1, 8, rxoh_pkg::OFF_CTRL, 32'h1);
    for (int n = 0; n < 16; n++) begin
      t = n[0] ? {n[2], 1'h1, n[1] ^ n[3], n[3], n[2] ^ n[1], 3'h5} : {n[1], 7'h1b};
      if (n[0]) begin
        naf = t;
        sina[n / 2] = t[7];
        ra[n / 2] = t[5];
        sa4[n / 2] = t[4];
        sa5[n / 2] = t[3];
      end else begin
        af = t;
        sia[n / 2] = t[7];
      end
      i_line.frame(0, 4'(n), t);
    end
    rd(1, rxoh_pkg::OFF_W64, af, "align frame");
    rd(1, rxoh_pkg::OFF_W65, naf, "nonalign frame");
    rd(1, rxoh_pkg::OFF_W66, sia, "si even");
    rd(1, rxoh_pkg::OFF_SINA, sina, "si odd");
    rd(1, rxoh_pkg::OFF_RA, ra, "remote alarm");
    rd(1, rxoh_pkg::OFF_SA4, sa4, "sa4 bits");
    rd(1, rxoh_pkg::OFF_SA5, sa5, "sa5 bits");
    $display("test e1 capture done");
    hcrc[7] <= 1'h1;
    hfas[7] <= 1'h1;
    rd(8, rxoh_pkg::OFF_LINK, 8'h05, "status crc fas");
    hcrc[7] <= 1'h0;
    hfas[7] <= 1'h0;
    hcas[7] <= 1'h1;
    rd(8, rxoh_pkg::OFF_LINK, 8'h02, "status cas");
    hcas[7] <= 1'h0;
    hcrc[7] <= 1'h1;
    apb(1'h1, 8, rxoh_pkg::OFF_CTRL, 32'h5);
    repeat (SC + 10) @(posedge core_clk_i);
    chk("line mode select", 32'h81, {24'h0, lmode});
    chk("crc enable", 32'h80, {24'h0, lcrc});
    rd(8, rxoh_pkg::OFF_LINK, 8'h0c, "count one");
    repeat (64 * SC) @(posedge core_clk_i);
    rd(8, rxoh_pkg::OFF_LINK, 8'hfc, "count saturated");
    sok[7] <= 1'h1;
    hcrc[7] <= 1'h0;
    // the counter clears one edge after sync; the setup edge already samples the cleared count
    @(posedge core_clk_i);
    rd(8, rxoh_pkg::OFF_LINK, 8'h00, "sync clears");
    sok[7] <= 1'h0;
    hcrc[7] <= 1'h1;
    repeat (2 * SC + 10) @(posedge core_clk_i);
    rd(8, rxoh_pkg::OFF_LINK, 8'h04, "count two hidden");
    repeat (SC) @(posedge core_clk_i);
    rd(8, rxoh_pkg::OFF_LINK, 8'h0c, "count three");
    apb(1'h1, 8, rxoh_pkg::OFF_CTRL, 32'h1);
    @(posedge core_clk_i);
    rd(8, rxoh_pkg::OFF_LINK, 8'h04, "disable clears");
    $display("test e1 status done");
    rd(1, 9'h06b, 8'h00, "unmapped data");
    chk("unmapped slverr", 32'h1, {31'h0, rerr});
    $display("test unmapped done");
    test_done();
  end
endmodule
`default_nettype wire
